/* File: src/load_ctrl_pkg.sv */
/*
  Package for the load shedding / step add-subtract controller:
  register offsets, field positions, reset values and widths.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package load_ctrl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PWR_W   = 16;
  localparam int unsigned DLY_W   = 32;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned NUM_DO  = 8;
  localparam int unsigned SEL_W   = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_LOW_LIMIT  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_HIGH_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SAME_DLY   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OPP_DLY    = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DO_MAP     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h14;

  // ----------------------------------------------------------------
  // output-map function codes, one per digital output
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] FN_OFF   = 3'h0;
  localparam logic [SEL_W-1:0] FN_SHED  = 3'h1;
  localparam logic [SEL_W-1:0] FN_DUMMY = 3'h2;
  localparam logic [SEL_W-1:0] FN_ADD   = 3'h3;
  localparam logic [SEL_W-1:0] FN_SUB   = 3'h4;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_SHED  = 0;
  localparam int unsigned ST_DUMMY = 1;
  localparam int unsigned ST_ADD   = 2;
  localparam int unsigned ST_SUB   = 3;
  localparam int unsigned ST_WAIT  = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PWR_W-1:0]  RST_LOW_LIMIT  = 16'h0000;
  localparam logic [PWR_W-1:0]  RST_HIGH_LIMIT = 16'hffff;
  localparam logic [DLY_W-1:0]  RST_DLY        = 32'h0000_0000;
  localparam logic [31:0]       RST_DO_MAP     = 32'h0000_0000;
  localparam logic [31:0]       RD_ZERO        = 32'h0000_0000;

endpackage : load_ctrl_pkg

/* File: src/gap_timer.sv */
/*
  Down counter that measures time since a pulse start.
  Loaded with a programmed count on start; expired when it reaches zero.
  Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module gap_timer #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         start,
  input  wire logic [W-1:0] load_val,
  // state
  output logic              expired
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired = (cnt_ff == '0);

endmodule : gap_timer
`default_nettype wire

/* File: src/load_shed_add_subtract_ctrl.sv */
/*
  Load shedding, dummy load and step add/subtract controller with APB registers.
  Compares genset active power against low/high limits and drives mappable
  digital outputs. Assumes power_kw is synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module load_shed_add_subtract_ctrl
(
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [load_ctrl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // measurement
  input  wire logic [load_ctrl_pkg::PWR_W-1:0]   power_kw,
  // load control outputs
  output logic                                   shed_out,
  output logic                                   dummy_out,
  output logic                                   add_out,
  output logic                                   sub_out,
  output logic      [load_ctrl_pkg::NUM_DO-1:0]  dig_out
);
  import load_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [PWR_W-1:0]         low_ff, nxt_low;
  logic [PWR_W-1:0]         high_ff, nxt_high;
  logic [DLY_W-1:0]         same_ff, nxt_same;
  logic [DLY_W-1:0]         opp_ff, nxt_opp;
  logic [31:0]              map_ff, nxt_map;
  logic [31:0]              prdata_ff, nxt_prdata;
  logic                     pslverr_ff, nxt_pslverr;
  logic                     access;
  logic                     hit;
  // load control state, declared here because status reads it back
  logic                     above_hi, below_lo;
  logic                     shed_ff, nxt_shed;
  logic                     dummy_ff, nxt_dummy;
  logic                     add_ff, nxt_add;
  logic                     sub_ff, nxt_sub;
  logic                     add_start, sub_start;
  logic                     add_gap_exp, sub_gap_exp, opp_exp;

  // zero-wait slave: the answer comes in the first access cycle
  assign access = psel && penable;

  always_comb begin
    nxt_low     = low_ff;
    nxt_high    = high_ff;
    nxt_same    = same_ff;
    nxt_opp     = opp_ff;
    nxt_map     = map_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    hit         = 1'b1;
    // read data is registered in setup so it is valid during access
    if (psel && !penable) begin
      case (paddr)
        REG_LOW_LIMIT:  nxt_prdata = {16'h0000, low_ff};
        REG_HIGH_LIMIT: nxt_prdata = {16'h0000, high_ff};
        REG_SAME_DLY:   nxt_prdata = same_ff;
        REG_OPP_DLY:    nxt_prdata = opp_ff;
        REG_DO_MAP:     nxt_prdata = map_ff;
        REG_STATUS:     nxt_prdata = {27'h0000000, !opp_exp, sub_ff, add_ff,
                                      !shed_ff, shed_ff};
        default: begin
          nxt_prdata = RD_ZERO;
          hit        = 1'b0;
        end
      endcase
      nxt_pslverr = !hit;
    end else if (access) begin
      nxt_pslverr = pslverr_ff;
      if (pwrite) begin
        case (paddr)
          REG_LOW_LIMIT:  nxt_low  = pwdata[PWR_W-1:0];
          REG_HIGH_LIMIT: nxt_high = pwdata[PWR_W-1:0];
          REG_SAME_DLY:   nxt_same = pwdata;
          REG_OPP_DLY:    nxt_opp  = pwdata;
          REG_DO_MAP:     nxt_map  = pwdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_ff     <= RST_LOW_LIMIT;
      high_ff    <= RST_HIGH_LIMIT;
      same_ff    <= RST_DLY;
      opp_ff     <= RST_DLY;
      map_ff     <= RST_DO_MAP;
      prdata_ff  <= RD_ZERO;
      pslverr_ff <= 1'b0;
    end else begin
      low_ff     <= nxt_low;
      high_ff    <= nxt_high;
      same_ff    <= nxt_same;
      opp_ff     <= nxt_opp;
      map_ff     <= nxt_map;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pready  = 1'b1;

  // ----------------------------------------------------------------
  // limit comparison and load control
  // ----------------------------------------------------------------
  assign above_hi = power_kw > high_ff;
  assign below_lo = power_kw < low_ff;

  // a new pulse starts only when both its own spacing and the
  // opposite-direction spacing have run out; a request gone by then is dropped, not stored
  assign add_start = !add_ff && below_lo && add_gap_exp && opp_exp;
  assign sub_start = !sub_ff && above_hi && sub_gap_exp && opp_exp;

  always_comb begin
    nxt_shed = shed_ff;
    if (above_hi) begin
      nxt_shed = 1'b1;
    end else if (below_lo) begin
      nxt_shed = 1'b0;
    end
    nxt_add = add_ff;
    if (add_start) begin
      nxt_add = 1'b1;
    end else if (add_ff && !below_lo) begin
      nxt_add = 1'b0;
    end
    nxt_sub = sub_ff;
    if (sub_start) begin
      nxt_sub = 1'b1;
    end else if (sub_ff && !above_hi) begin
      nxt_sub = 1'b0;
    end
    // registered so the dummy pin comes straight from a flop
    nxt_dummy = !nxt_shed;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shed_ff     <= 1'b0;
      dummy_ff    <= 1'b1;
      add_ff      <= 1'b0;
      sub_ff      <= 1'b0;
    end else begin
      shed_ff     <= nxt_shed;
      dummy_ff    <= nxt_dummy;
      add_ff      <= nxt_add;
      sub_ff      <= nxt_sub;
    end
  end

  // ----------------------------------------------------------------
  // pulse spacing timers
  // ----------------------------------------------------------------
  gap_timer #(.W(DLY_W)) u_add_gap (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (add_start),
    .load_val (same_ff),
    .expired  (add_gap_exp)
  );

  gap_timer #(.W(DLY_W)) u_sub_gap (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (sub_start),
    .load_val (same_ff),
    .expired  (sub_gap_exp)
  );

  gap_timer #(.W(DLY_W)) u_opp_gap (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (add_start || sub_start),
    .load_val (opp_ff),
    .expired  (opp_exp)
  );

  // ----------------------------------------------------------------
  // output mapping
  // ----------------------------------------------------------------
  logic [NUM_DO-1:0] do_ff, nxt_do;

  always_comb begin
    for (int i = 0; i < NUM_DO; i++) begin
      case (map_ff[i*4 +: SEL_W])
        FN_SHED:  nxt_do[i] = nxt_shed;
        FN_DUMMY: nxt_do[i] = !nxt_shed;
        FN_ADD:   nxt_do[i] = nxt_add;
        FN_SUB:   nxt_do[i] = nxt_sub;
        default:  nxt_do[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_ff <= '0;
    end else begin
      do_ff <= nxt_do;
    end
  end

  assign shed_out  = shed_ff;
  assign dummy_out = dummy_ff;
  assign add_out   = add_ff;
  assign sub_out   = sub_ff;
  assign dig_out   = do_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence hi_seen;
    above_hi;
  endsequence

  // cycles since the last add start, saturating; starts saturated so the
  // first pulse after reset is never judged too close
  logic [DLY_W-1:0] add_since_ff, nxt_add_since;

  always_comb begin
    nxt_add_since = add_since_ff;
    if (add_start) begin
      nxt_add_since = '0;
    end else if (add_since_ff != '1) begin
      nxt_add_since = add_since_ff + DLY_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_since_ff <= '1;
    end else begin
      add_since_ff <= nxt_add_since;
    end
  end

  shed_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    hi_seen |=> shed_out) else $error("shed not set above high limit");
  shed_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    below_lo && !above_hi |=> !shed_out) else $error("shed not released");
  shed_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    map_ff[2:0] == FN_SHED && $stable(map_ff) |=> dig_out[0] == shed_out)
    else $error("mapped shed output wrong");
  dummy_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    dummy_out != shed_out) else $error("dummy not inverse of shed");
  add_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
    add_out && !below_lo |=> !add_out) else $error("add not released");
  sub_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
    sub_out && !above_hi |=> !sub_out) else $error("sub not released");
  add_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    map_ff[6:4] == FN_ADD && $stable(map_ff) |=> dig_out[1] == add_out)
    else $error("mapped add output wrong");
  add_space_a: assert property (@(posedge pclk) disable iff (!presetn)
    add_start |-> add_since_ff >= same_ff)
    else $error("add pulses too close");
  opp_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    !opp_exp |=> !$rose(add_out) && !$rose(sub_out))
    else $error("pulse before opposite delay");
  hold_mid_a: assert property (@(posedge pclk) disable iff (!presetn)
    !above_hi && !below_lo |=> $stable(shed_out))
    else $error("shed changed between limits");

endmodule : load_shed_add_subtract_ctrl
`default_nettype wire

/* File: verif/load_sys_model.sv */
/*
  Behavioural multi-step load system on the far side of the controller.
  Assumes the add and subtract levels of the controller and one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module load_sys_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bench control
  input  wire logic        follow,
  input  wire logic        set_en,
  input  wire logic [15:0] set_val,
  input  wire logic [3:0]  rate,
  // controller side
  input  wire logic        add_out,
  input  wire logic        sub_out,
  output logic      [15:0] power_kw
);
  logic [3:0] tick;

  // ----------------------------------------------------------------
  // load stepping
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_kw <= 16'h0096;
      tick     <= 4'h0;
    end else if (set_en) begin
      power_kw <= set_val;
      tick     <= 4'h0;
    end else if (follow && (add_out || sub_out)) begin
      tick <= (tick >= rate) ? 4'h0 : tick + 4'h1;
      // a slow rate lets the controller see several samples per step
      if (tick >= rate) begin
        power_kw <= add_out ? power_kw + 16'h0007 : power_kw - 16'h0007;
      end
    end
  end
endmodule : load_sys_model
`default_nettype wire

/* File: verif/load_shed_add_subtract_ctrl_tb.sv */
/*
  Self-checking bench for the load shedding and step add/subtract controller.
  Assumes the load system model beside it and zero-wait APB access.
*/
`timescale 1ns/100ps
`default_nettype none
module load_shed_add_subtract_ctrl_tb;
  import load_ctrl_pkg::*;
  logic              pclk = 1'b0, presetn = 1'b0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, d;
  logic              pready, pslverr, shed_out, dummy_out, add_out, sub_out, e, s;
  logic [NUM_DO-1:0] dig_out;
  logic [PWR_W-1:0]  power_kw;
  logic              follow = 1'b0, set_en = 1'b0;
  logic [15:0]       set_val = 16'h0;
  logic [3:0]        rate = 4'h1;
  int                bad_count = 0, n_tests = 0, cyc = 0, t0, t1, t2;

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  load_shed_add_subtract_ctrl u_load_shed_add_subtract_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_kw(power_kw), .shed_out(shed_out), .dummy_out(dummy_out), .add_out(add_out),
    .sub_out(sub_out), .dig_out(dig_out));
  load_sys_model u_load_sys_model (
    .pclk(pclk), .presetn(presetn), .follow(follow), .set_en(set_en), .set_val(set_val),
    .rate(rate), .add_out(add_out), .sub_out(sub_out), .power_kw(power_kw));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic ex, input logic got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", nm, ex, got);
    end
  endtask : chk_bit

  task automatic chk_outs(input logic sh, input logic ad, input logic sb);
    chk_bit("shed", sh, shed_out);
    chk_bit("dummy", ~sh, dummy_out);
    chk_bit("add", ad, add_out);
    chk_bit("sub", sb, sub_out);
    chk_word("dig_out", {28'h0, sb, ad, ~sh, sh}, {24'h0, dig_out});
  endtask : chk_outs

  // the request stands until pready is seen high at an edge
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_pwr(input logic [15:0] v);
    @(posedge pclk);
    set_val <= v;
    set_en  <= 1'b1;
    @(posedge pclk);
    set_en <= 1'b0;
  endtask : set_pwr

  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  task automatic wait_lvl(input logic sb, input logic lv, input int lim, output int at);
    s  = 1'b0;
    at = 0;
    for (int i = 0; i < lim && !s; i++) begin
      @(posedge pclk);
      #1;
      if ((sb ? sub_out : add_out) === lv) begin
        s  = 1'b1;
        at = cyc;
      end
    end
  endtask : wait_lvl

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    settle();
    chk_word("reset outs", 32'h0000_0400, {20'h0, shed_out, dummy_out, add_out, sub_out, dig_out});
    apb(REG_HIGH_LIMIT, 1'b0, 32'h0);
    chk_word("high reset", 32'h0000ffff, d);
    apb(8'h18, 1'b0, 32'h0);
    chk_bit("unmapped err", 1'b1, e);
    apb(REG_LOW_LIMIT, 1'b1, 32'h0000_0064);
    apb(REG_HIGH_LIMIT, 1'b1, 32'h0000_00c8);
    apb(REG_DO_MAP, 1'b1, 32'h0000_4321);
    apb(REG_STATUS, 1'b1, 32'h0000_00ff);
    apb(REG_STATUS, 1'b0, 32'h0);
    chk_word("status ro", 32'h0000_0002, d);
    chk_outs(1'b0, 1'b0, 1'b0);
    apb(REG_DO_MAP, 1'b0, 32'h0);
    chk_word("map", 32'h0000_4321, d);
    $display("test registers done");
  endtask : t_regs

  // limits 100 and 200; exact limits are neither above nor below
  task automatic t_levels;
    logic [15:0] pw [6] = '{16'd200, 16'd201, 16'd150, 16'd100, 16'd99, 16'd150};
    logic [2:0]  ex [6] = '{3'b000, 3'b101, 3'b100, 3'b100, 3'b010, 3'b000};
    for (int i = 0; i < 6; i++) begin
      set_pwr(pw[i]);
      settle();
      chk_outs(ex[i][2], ex[i][1], ex[i][0]);
    end
    $display("test levels done");
  endtask : t_levels

  task automatic t_follow;
    rate <= 4'h1;
    set_pwr(16'd50);
    follow <= 1'b1;
    wait_lvl(1'b0, 1'b1, 20, t0);
    wait_lvl(1'b0, 1'b0, 200, t0);
    chk_bit("add released", 1'b1, s);
    chk_bit("raised power", 1'b1, power_kw inside {[16'd100:16'd113]});
    rate <= 4'h4;
    set_pwr(16'd300);
    wait_lvl(1'b1, 1'b1, 20, t0);
    wait_lvl(1'b1, 1'b0, 300, t0);
    chk_bit("sub released", 1'b1, s);
    chk_bit("lowered power", 1'b1, power_kw inside {[16'd186:16'd199]});
    follow <= 1'b0;
    settle();
    chk_outs(1'b1, 1'b0, 1'b0);
    $display("test follow done");
  endtask : t_follow

  // same-direction gap 30, opposite gap 12 cycles
  task automatic t_gaps;
    apb(REG_SAME_DLY, 1'b1, 32'h0000_001e);
    apb(REG_OPP_DLY, 1'b1, 32'h0000_000c);
    set_pwr(16'd50);
    wait_lvl(1'b0, 1'b1, 20, t0);
    apb(REG_STATUS, 1'b0, 32'h0);
    chk_word("status run", 32'h0000_0016, d);
    set_pwr(16'd150);
    settle();
    chk_bit("add off", 1'b0, add_out);
    set_pwr(16'd50);
    wait_lvl(1'b0, 1'b1, 60, t1);
    chk_bit("same gap", 1'b1, (t1 - t0) inside {[28:34]});
    set_pwr(16'd250);
    wait_lvl(1'b1, 1'b1, 40, t2);
    chk_bit("opp gap", 1'b1, (t2 - t1) inside {[10:16]});
    set_pwr(16'd150);
    set_pwr(16'd50);
    set_pwr(16'd150);
    wait_lvl(1'b0, 1'b1, 25, t0);
    chk_bit("stale add", 1'b0, s);
    $display("test gaps done");
  endtask : t_gaps

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_levels();
    t_follow();
    t_gaps();
    stop_test();
  end

  // the whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    $display("unexpected timeout: expected end of run, seen hang");
    stop_test();
  end
endmodule : load_shed_add_subtract_ctrl_tb
`default_nettype wire
